// ===== rtl/lbi_cpu_end.sv
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
`include "lbi_defines.svh"
// Behaviour
// R1: Address in address state, data later
// R2: Lane code from high enable and a0
// R3: Upper lines address for memory, low I/O
// R4: Segment status pair; top bit low
// R5: Interrupt-enable status refreshed every clock
// R6: Float lines in interrupt and hold acknowledge
// R7: High enable low for upper byte
// R8: Read strobe low second/third/wait, late start
// R9: Ready must arrive clock-synchronous
// R10: Sample maskable request at instruction end
// R11: Rising non-maskable edge starts type two
// R12: Wait instruction idles while test high
// R13: Reset held four clocks, restarts after
// R14: Mode select low picks maximum pins
// R15: Status active final/address/second, then passive
// R16: Cycle status three-bit encoding
// R17: One-clock request, grant pulse, then hold
// R18: Release pulse returns bus next clock
// R19: Grant blocked odd-low, first ack, lock
// R20: Lock low through the next instruction
// R21: Queue status valid cycle after operation
// R22: Queue status two-bit encoding
// R23: Wait states until ready seen high
module lbi_cpu_end (
    input wire logic mclk,
    input wire logic sys_rst,
    lbi_bus_if.dev bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire lbi_pkg::lbi_cmd_t cmd,
    input wire logic irq_enable_flag,
    input wire logic instr_last,
    input wire logic wait_instr,
    input wire logic lock_prefix,
    input wire logic [1:0] queue_op,
    output logic [15:0] rdata_q,
    output logic rdata_valid_q,
    output logic irq_take_q,
    output logic nmi_take_q,
    output logic [7:0] irq_type_q,
    output logic wait_idle,
    output logic hold_active,
    output logic max_mode
);
    import lbi_pkg::*;
    lbi_tstate_t st_q;
    lbi_cmd_t cur_q;
    logic [2:0] rst_sync_q;
    logic dev_rst;
    logic ready_seen;
    logic hold_q;
    logic grant_q;
    logic [1:0] grant_ch_q;
    logic [1:0] req_pend_q;
    logic hold_ch_q;
    logic nmi_s1_q, nmi_s2_q, nmi_s3_q, nmi_pend_q;
    logic irq_s1_q, irq_s2_q;
    logic test_s1_q, test_s2_q;
    logic lock_q;
    logic lock_arm_q;
    logic [1:0] qs_q;
    logic ie_q;
    logic is_read;
    logic is_io;
    logic [2:0] cs_d;
    logic grant_ok;

    // Read-type status codes
    function automatic logic cs_is_read(input logic [2:0] k);
        cs_is_read = (k == `LBI_CS_IORD) || (k == `LBI_CS_MEMRD) || (k == `LBI_CS_CODE);
    endfunction : cs_is_read

    // Reset synchroniser; clears activity at once and releases after sync
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_sync_q <= 3'h7;
        end else begin
            rst_sync_q <= {rst_sync_q[1:0], bus.reset}; // R13
        end
    end
    assign dev_rst = bus.reset | rst_sync_q[1] | rst_sync_q[2]; // R13
    assign max_mode = !bus.mode_select; // R14
    assign is_io = (cur_q.kind == `LBI_CS_IORD) || (cur_q.kind == `LBI_CS_IOWR);
    assign is_read = cs_is_read(cur_q.kind) || (cur_q.kind == `LBI_CS_INTA);
    assign ready_seen = bus.ready; // R9
    assign cmd_ready = (st_q == LBI_TI || st_q == LBI_T4) && !hold_q && !grant_q && !grant_ok
                       && !dev_rst;
    assign hold_active = hold_q;

    // Bus state sequence with wait insertion
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= LBI_TI;
            cur_q <= '0;
        end else if (dev_rst) begin
            st_q <= LBI_TI;
        end else begin
            case (st_q)
                LBI_TI, LBI_T4: begin
                    if (cmd_valid && cmd_ready && !grant_ok) begin
                        st_q <= LBI_T1;
                        cur_q <= cmd;
                    end else begin
                        st_q <= LBI_TI;
                    end
                end
                LBI_T1: st_q <= LBI_T2;
                LBI_T2: st_q <= LBI_T3;
                LBI_T3, LBI_TW: st_q <= ready_seen ? LBI_T4 : LBI_TW; // R23
                default: st_q <= LBI_TI;
            endcase
        end
    end

    // Cycle status: next cycle code shows in final state, passive after second
    always_comb begin
        cs_d = `LBI_CS_PASSIVE;
        if (st_q == LBI_T1 || st_q == LBI_T2) begin
            cs_d = cur_q.kind; // R15 R16
        end else if ((st_q == LBI_TI || st_q == LBI_T4) && cmd_valid && cmd_ready && !grant_ok) begin
            cs_d = cmd.kind; // R15
        end
    end
    assign bus.cycle_status_lines = cs_d; // R15

    // Address/data lines: address in address state, data or float later
    always_comb begin
        bus.ad_o = 16'h0000;
        bus.ad_oe_n = 16'hFFFF;
        if (!hold_q && st_q == LBI_T1) begin
            bus.ad_o = cur_q.addr[15:0]; // R1
            bus.ad_o[0] = cur_q.word ? 1'b0 : cur_q.addr[0]; // R2
            bus.ad_oe_n = (cur_q.kind == `LBI_CS_INTA) ? 16'hFFFF : 16'h0000; // R6
        end else if (!hold_q && !is_read && st_q != LBI_TI
                     && cur_q.kind != `LBI_CS_HALT) begin
            bus.ad_o = cur_q.wdata; // R1
            bus.ad_oe_n = 16'h0000;
        end
    end

    // Upper address/status lines
    always_comb begin
        bus.upper_o = 4'h0;
        if (st_q == LBI_T1) begin
            bus.upper_o = is_io ? 4'h0 : cur_q.addr[19:16]; // R3
        end else begin
            bus.upper_o = {1'b0, ie_q, cur_q.seg}; // R3 R4 R5
        end
    end
    assign bus.upper_oe_n = hold_q; // R6
    assign bus.ctl_oe_n = hold_q; // R6

    // High-byte enable and its status bit
    always_comb begin
        if (st_q == LBI_T1) begin
            bus.high_byte_enable_n = !(cur_q.word || cur_q.addr[0]); // R2 R7
        end else begin
            bus.high_byte_enable_n = 1'b0; // R7
        end
    end

    // Read strobe low in second, third, wait of reads
    assign bus.rd_n = !((st_q == LBI_T2 || st_q == LBI_T3 || st_q == LBI_TW)
                       && cs_is_read(cur_q.kind)); // R8

    // Interrupt-enable status refreshed each clock
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ie_q <= 1'b0;
        end else begin
            ie_q <= irq_enable_flag; // R5
        end
    end

    // Read data capture at end of transfer
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 16'h0000;
            rdata_valid_q <= 1'b0;
        end else begin
            rdata_valid_q <= 1'b0;
            if ((st_q == LBI_T3 || st_q == LBI_TW) && ready_seen && is_read) begin
                rdata_q <= bus.ad_i;
                rdata_valid_q <= 1'b1;
            end
        end
    end

    // Interrupt synchronisers and sampling at instruction end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_s1_q <= 1'b0;
            irq_s2_q <= 1'b0;
            nmi_s1_q <= 1'b0;
            nmi_s2_q <= 1'b0;
            nmi_s3_q <= 1'b0;
            nmi_pend_q <= 1'b0;
            irq_take_q <= 1'b0;
            nmi_take_q <= 1'b0;
            irq_type_q <= 8'h00;
        end else begin
            irq_s1_q <= bus.maskable_irq_request;
            irq_s2_q <= irq_s1_q; // R10
            nmi_s1_q <= bus.nmi;
            nmi_s2_q <= nmi_s1_q; // R11
            nmi_s3_q <= nmi_s2_q;
            irq_take_q <= 1'b0;
            nmi_take_q <= 1'b0;
            if (instr_last && !dev_rst) begin
                irq_take_q <= irq_s2_q && irq_enable_flag; // R10
                nmi_take_q <= nmi_pend_q; // R11
                nmi_pend_q <= 1'b0;
                if (nmi_pend_q) begin
                    irq_type_q <= `LBI_NMI_TYPE; // R11
                end
            end
            if (nmi_s2_q && !nmi_s3_q) begin
                nmi_pend_q <= 1'b1; // R11
            end
        end
    end

    // Test input synchronised; wait instruction idles while it is high
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            test_s1_q <= 1'b1;
            test_s2_q <= 1'b1;
        end else begin
            test_s1_q <= bus.test_n;
            test_s2_q <= test_s1_q; // R12
        end
    end
    assign wait_idle = wait_instr && test_s2_q; // R12

    // Lock output held through the instruction after the prefix
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            lock_q <= 1'b0;
            lock_arm_q <= 1'b0;
        end else if (dev_rst) begin
            lock_q <= 1'b0;
            lock_arm_q <= 1'b0;
        end else if (lock_prefix) begin
            lock_q <= 1'b1; // R20
            lock_arm_q <= 1'b0;
        end else if (lock_q && instr_last) begin
            lock_arm_q <= 1'b1;
            lock_q <= lock_arm_q ? 1'b0 : lock_q; // R20
        end
    end
    assign bus.lock_n = !lock_q; // R20

    // Queue status presented the cycle after the operation
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            qs_q <= `LBI_QS_NOP;
        end else begin
            qs_q <= queue_op; // R21 R22
        end
    end
    assign bus.queue_status_pair = max_mode ? qs_q : `LBI_QS_NOP; // R14

    // Grant allowed at final or idle, not odd-low, first ack or lock
    assign grant_ok = (req_pend_q != 2'h0) && !hold_q && !grant_q && max_mode
                      && (st_q == LBI_TI || st_q == LBI_T4)
                      && !(cur_q.odd_low && st_q == LBI_T4)
                      && !(cur_q.first_inta && st_q == LBI_T4)
                      && !lock_q; // R19

    // Request/grant exchange
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            req_pend_q <= 2'h0;
            grant_q <= 1'b0;
            grant_ch_q <= 2'h0;
            hold_q <= 1'b0;
            hold_ch_q <= 1'b0;
        end else if (dev_rst) begin
            req_pend_q <= 2'h0;
            grant_q <= 1'b0;
            hold_q <= 1'b0;
        end else begin
            grant_q <= 1'b0;
            if (!hold_q && !grant_q) begin
                req_pend_q <= req_pend_q | ~bus.bus_request_grant; // R17
            end
            if (grant_ok) begin
                grant_q <= 1'b1; // R17
                hold_ch_q <= !req_pend_q[0]; // R17
                grant_ch_q <= req_pend_q[0] ? 2'h1 : 2'h2;
                req_pend_q <= 2'h0;
            end
            if (grant_q) begin
                hold_q <= 1'b1; // R17
            end else if (hold_q && !bus.bus_request_grant[hold_ch_q]) begin
                hold_q <= 1'b0; // R18
            end
        end
    end
    assign bus.rqgt_dev_o = 2'h0;
    assign bus.rqgt_dev_oe_n = grant_q ? ~grant_ch_q : 2'h3; // R17
endmodule : lbi_cpu_end

// ===== rtl/lbi_defines.svh
`ifndef LBI_DEFINES_SVH
`define LBI_DEFINES_SVH
// Cycle status encodings
`define LBI_CS_INTA 3'h0
`define LBI_CS_IORD 3'h1
`define LBI_CS_IOWR 3'h2
`define LBI_CS_HALT 3'h3
`define LBI_CS_CODE 3'h4
`define LBI_CS_MEMRD 3'h5
`define LBI_CS_MEMWR 3'h6
`define LBI_CS_PASSIVE 3'h7
// Segment status encodings
`define LBI_SEG_ALT 2'h0
`define LBI_SEG_STACK 2'h1
`define LBI_SEG_CODE 2'h2
`define LBI_SEG_DATA 2'h3
// Queue status encodings
`define LBI_QS_NOP 2'h0
`define LBI_QS_FIRST 2'h1
`define LBI_QS_EMPTY 2'h2
`define LBI_QS_NEXT 2'h3
// Lane encodings {high_byte_enable_n, a0}
`define LBI_LANE_WORD 2'h0
`define LBI_LANE_HIGH 2'h1
`define LBI_LANE_LOW 2'h2
`define LBI_LANE_NONE 2'h3
// Minimum reset hold, clock cycles
`define LBI_RESET_MIN_CYCLES 3'h4
// Non-maskable interrupt type
`define LBI_NMI_TYPE 8'h02
`endif

// ===== rtl/lbi_pkg.sv
package lbi_pkg;
    typedef enum logic [2:0] {
        LBI_TI, LBI_T1, LBI_T2, LBI_T3, LBI_TW, LBI_T4
    } lbi_tstate_t;
    typedef struct packed {
        logic [2:0] kind;
        logic [19:0] addr;
        logic word;
        logic [1:0] seg;
        logic [15:0] wdata;
        logic locked;
        logic odd_low;
        logic first_inta;
    } lbi_cmd_t;
endpackage : lbi_pkg

// ===== rtl/lbi_bus_if.sv
`timescale 1ns/1ns
interface lbi_bus_if;
    logic [15:0] ad_o;
    logic [15:0] ad_oe_n;
    logic [15:0] ad_i;
    logic [3:0] upper_o;
    logic upper_oe_n;
    logic high_byte_enable_n;
    logic ctl_oe_n;
    logic rd_n;
    logic [2:0] cycle_status_lines;
    logic lock_n;
    logic [1:0] queue_status_pair;
    logic ready;
    logic maskable_irq_request;
    logic nmi;
    logic test_n;
    logic reset;
    logic mode_select;
    logic [1:0] rqgt_dev_o;
    logic [1:0] rqgt_dev_oe_n;
    logic [1:0] rqgt_mst_o;
    logic [1:0] rqgt_mst_oe_n;
    logic [1:0] bus_request_grant;
    assign bus_request_grant = ~((~rqgt_dev_o & ~rqgt_dev_oe_n) | (~rqgt_mst_o & ~rqgt_mst_oe_n));
    assign ad_i = ad_o;
    modport dev (
        output ad_o, ad_oe_n, upper_o, upper_oe_n, high_byte_enable_n, ctl_oe_n, rd_n,
        output cycle_status_lines, lock_n, queue_status_pair, rqgt_dev_o, rqgt_dev_oe_n,
        input ad_i, ready, maskable_irq_request, nmi, test_n, reset, mode_select,
        input bus_request_grant
    );
    modport ext (
        input ad_o, ad_oe_n, upper_o, upper_oe_n, high_byte_enable_n, ctl_oe_n, rd_n,
        input cycle_status_lines, lock_n, queue_status_pair, bus_request_grant,
        output ready, maskable_irq_request, nmi, test_n, reset, mode_select,
        output rqgt_mst_o, rqgt_mst_oe_n
    );
endinterface : lbi_bus_if

// ===== rtl/lbi_ext_end.sv
`timescale 1ns/1ns
`include "lbi_defines.svh"
// External side: drives ready, reset, interrupts and one request/grant channel.
module lbi_ext_end (
    input wire logic mclk,
    input wire logic sys_rst,
    lbi_bus_if.ext bus,
    input wire logic usr_ready,
    input wire logic usr_irq,
    input wire logic usr_nmi,
    input wire logic usr_test_n,
    input wire logic usr_reset_req,
    input wire logic usr_bus_want,
    input wire logic usr_bus_chan,
    output logic usr_bus_owned,
    output logic [15:0] usr_rdata,
    output logic usr_rdata_valid,
    output logic [2:0] usr_last_status
);
    import lbi_pkg::*;
    typedef enum logic [1:0] {LBI_M_IDLE, LBI_M_WAITG, LBI_M_OWN} lbi_mst_t;
    lbi_mst_t mst_q;
    logic [2:0] rst_cnt_q;
    logic ready_q;
    logic pulse_q;
    // Reset held for the least count of cycles
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_cnt_q <= 3'h0;
        end else if (usr_reset_req) begin
            rst_cnt_q <= `LBI_RESET_MIN_CYCLES; // R13
        end else if (rst_cnt_q != 3'h0) begin
            rst_cnt_q <= rst_cnt_q - 3'h1;
        end
    end
    assign bus.reset = sys_rst | usr_reset_req | (rst_cnt_q != 3'h0); // R13
    // Ready registered on the clock
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= usr_ready; // R9
        end
    end
    assign bus.ready = ready_q;
    assign bus.maskable_irq_request = usr_irq;
    assign bus.nmi = usr_nmi;
    assign bus.test_n = usr_test_n;
    assign bus.mode_select = 1'b0;
    // Request, wait grant, own, release pulses
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            mst_q <= LBI_M_IDLE;
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= 1'b0;
            case (mst_q)
                LBI_M_IDLE: begin
                    if (usr_bus_want && !bus.reset) begin
                        pulse_q <= 1'b1; // R17
                        mst_q <= LBI_M_WAITG;
                    end
                end
                LBI_M_WAITG: begin
                    if (!pulse_q && !bus.bus_request_grant[usr_bus_chan]) begin
                        mst_q <= LBI_M_OWN;
                    end
                end
                LBI_M_OWN: begin
                    if (!usr_bus_want) begin
                        pulse_q <= 1'b1; // R18
                        mst_q <= LBI_M_IDLE;
                    end
                end
                default: mst_q <= LBI_M_IDLE;
            endcase
        end
    end
    assign bus.rqgt_mst_o = 2'h0;
    assign bus.rqgt_mst_oe_n = pulse_q ? (usr_bus_chan ? 2'h1 : 2'h2) : 2'h3;
    assign usr_bus_owned = (mst_q == LBI_M_OWN);
    // Capture read data at end of read and observed status
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            usr_rdata <= 16'h0000;
            usr_rdata_valid <= 1'b0;
            usr_last_status <= `LBI_CS_PASSIVE;
        end else begin
            usr_rdata_valid <= 1'b0;
            if (bus.cycle_status_lines != `LBI_CS_PASSIVE) begin
                usr_last_status <= bus.cycle_status_lines;
            end
            if (!bus.rd_n && ready_q) begin
                usr_rdata <= bus.ad_o;
                usr_rdata_valid <= 1'b1;
            end
        end
    end
endmodule : lbi_ext_end

// ===== sim/lbi_bus_checker.sv
`timescale 1ns/1ns
// Watches the wire between the two ends
module lbi_bus_checker (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [15:0] ad_oe_n,
    input wire logic [3:0] upper_o,
    input wire logic upper_oe_n,
    input wire logic ctl_oe_n,
    input wire logic rd_n,
    input wire logic [2:0] cycle_status_lines,
    input wire logic reset,
    input wire logic [1:0] rqgt_dev_o,
    input wire logic [1:0] rqgt_dev_oe_n,
    input wire logic [1:0] rqgt_mst_o,
    input wire logic [1:0] rqgt_mst_oe_n
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // Request/grant lines pulled low by each side
    wire logic [1:0] dev_low = ~rqgt_dev_o & ~rqgt_dev_oe_n;
    wire logic [1:0] mst_low = ~rqgt_mst_o & ~rqgt_mst_oe_n;
    // Read strobe, status, float, request/grant pulse and reset hold relations
    rd_float_a: assert property (!rd_n |-> ad_oe_n == 16'hFFFF)
        else $error("read strobe low with lines driven");
    top_status_a: assert property (!rd_n |-> !upper_o[3])
        else $error("top status bit high");
    hold_float_a: assert property (upper_oe_n |-> ad_oe_n == 16'hFFFF && ctl_oe_n)
        else $error("lines driven in hold");
    read_kind_a: assert property ($fell(rd_n) |-> cycle_status_lines inside {3'h1, 3'h4, 3'h5})
        else $error("read strobe in a non-read cycle");
    passive_t3_a: assert property ($fell(rd_n) |=> cycle_status_lines == 3'h7)
        else $error("status not passive in third state");
    io_upper_a: assert property (($fell(rd_n) && cycle_status_lines == 3'h1)
        |-> $past(upper_o) == 4'h0)
        else $error("upper lines not low for io");
    strobe_follow_a: assert property (($changed(cycle_status_lines)
        && (cycle_status_lines inside {3'h1, 3'h5})) |-> ##[1:3] !rd_n)
        else $error("no read strobe after read status");
    grant_pulse_a: assert property (dev_low[0] |=> !dev_low[0])
        else $error("grant pulse on line 0 too long");
    grant_one_a: assert property (dev_low[1] |=> !dev_low[1])
        else $error("grant pulse on line 1 too long");
    req_pulse_a: assert property (mst_low[0] |=> !mst_low[0])
        else $error("request pulse too long");
    reset_hold_a: assert property ($rose(reset) |-> reset [*4])
        else $error("reset shorter than four clocks");
endmodule : lbi_bus_checker

// ===== sim/cpu_local_bus_interface_tb.sv
`timescale 1ns/1ns
module cpu_local_bus_interface_tb;
    import lbi_pkg::*;
    logic mclk = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0, irq_enable_flag = 1'b0;
    logic instr_last = 1'b0, wait_instr = 1'b0, lock_prefix = 1'b0, usr_ready = 1'b1;
    logic usr_irq = 1'b0, usr_nmi = 1'b0, usr_test_n = 1'b0, usr_reset_req = 1'b0;
    logic usr_bus_want = 1'b0, usr_bus_chan = 1'b0;
    logic [1:0] queue_op = 2'h0;
    lbi_cmd_t cmd = '0;
    logic cmd_ready, rdata_valid_q, irq_take_q, nmi_take_q, wait_idle, hold_active, max_mode;
    logic usr_bus_owned, usr_rdata_valid;
    logic [15:0] rdata_q, usr_rdata;
    logic [7:0] irq_type_q;
    logic [2:0] usr_last_status;
    int num_errors = 0, checks_done = 0, cyc = 0, j, ni, nn;
    int seed = 32'h058c;
    logic [2:0] kinds [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    lbi_bus_if lbi_bus_if_i ();
    lbi_cpu_end lbi_cpu_end_i (.mclk(mclk), .sys_rst(sys_rst), .bus(lbi_bus_if_i),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
        .irq_enable_flag(irq_enable_flag), .instr_last(instr_last), .wait_instr(wait_instr),
        .lock_prefix(lock_prefix), .queue_op(queue_op), .rdata_q(rdata_q),
        .rdata_valid_q(rdata_valid_q), .irq_take_q(irq_take_q), .nmi_take_q(nmi_take_q),
        .irq_type_q(irq_type_q), .wait_idle(wait_idle), .hold_active(hold_active),
        .max_mode(max_mode));
    lbi_ext_end lbi_ext_end_i (.mclk(mclk), .sys_rst(sys_rst), .bus(lbi_bus_if_i),
        .usr_ready(usr_ready), .usr_irq(usr_irq), .usr_nmi(usr_nmi), .usr_test_n(usr_test_n),
        .usr_reset_req(usr_reset_req), .usr_bus_want(usr_bus_want),
        .usr_bus_chan(usr_bus_chan), .usr_bus_owned(usr_bus_owned), .usr_rdata(usr_rdata),
        .usr_rdata_valid(usr_rdata_valid), .usr_last_status(usr_last_status));
    lbi_bus_checker lbi_bus_checker_i (.mclk(mclk), .sys_rst(sys_rst),
        .ad_oe_n(lbi_bus_if_i.ad_oe_n), .upper_o(lbi_bus_if_i.upper_o),
        .upper_oe_n(lbi_bus_if_i.upper_oe_n), .ctl_oe_n(lbi_bus_if_i.ctl_oe_n),
        .rd_n(lbi_bus_if_i.rd_n), .cycle_status_lines(lbi_bus_if_i.cycle_status_lines),
        .reset(lbi_bus_if_i.reset), .rqgt_dev_o(lbi_bus_if_i.rqgt_dev_o),
        .rqgt_dev_oe_n(lbi_bus_if_i.rqgt_dev_oe_n), .rqgt_mst_o(lbi_bus_if_i.rqgt_mst_o),
        .rqgt_mst_oe_n(lbi_bus_if_i.rqgt_mst_oe_n));
    // Clock and hang guard
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            finish_test();
        end
    end
    // Compares one result and counts it
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One bus cycle with a chosen number of wait states, checked state by state
    task automatic bus_cycle(input logic [2:0] kind, input int waits);
        lbi_cmd_t c;
        logic [31:0] r;
        logic rd, io;
        int i;
        r = $random(seed);
        c = '0;
        c.kind = kind;
        c.addr = r[19:0];
        c.word = r[20];
        c.addr[0] = r[21] & ~r[20];
        c.seg = r[23:22];
        r = $random(seed);
        c.wdata = r[15:0];
        rd = (kind == 3'h1 || kind == 3'h4 || kind == 3'h5);
        io = (kind == 3'h1 || kind == 3'h2);
        @(posedge mclk);
        usr_ready <= (waits == 0);
        irq_enable_flag <= r[16];
        cmd <= c;
        cmd_valid <= 1'b1;
        #1;
        for (i = 0; i < 20 && cmd_ready !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        @(posedge mclk);
        cmd_valid <= 1'b0;
        #1;
        for (i = 0; i < 6 && lbi_bus_if_i.ad_oe_n !== 16'h0000; i++) begin
            @(posedge mclk);
            #1;
        end
        chk(lbi_bus_if_i.ad_o, c.addr[15:0]);
        chk(lbi_bus_if_i.upper_o, io ? 4'h0 : c.addr[19:16]);
        chk({lbi_bus_if_i.high_byte_enable_n, lbi_bus_if_i.ad_o[0]},
            {~(c.word | c.addr[0]), c.addr[0]});
        chk(lbi_bus_if_i.cycle_status_lines, kind);
        for (i = 2; i <= 5 + waits; i++) begin
            @(posedge mclk);
            if (i == 2 + waits)
                usr_ready <= 1'b1;
            #1;
            if (i == 2)
                chk(lbi_bus_if_i.upper_o, {1'b0, r[16], c.seg});
            if (i == 2 && !rd)
                chk(lbi_bus_if_i.ad_o, c.wdata);
            if (i == 3)
                chk(lbi_bus_if_i.cycle_status_lines, 3'h7);
            chk(lbi_bus_if_i.rd_n, !(rd && i <= 3 + waits));
            if (i == 4 + waits)
                chk(usr_last_status, kind);
            chk(rdata_valid_q, rd && i == 4 + waits);
        end
    endtask : bus_cycle
    // Ends an instruction and counts interrupt takes that follow
    task automatic pulse_last();
        ni = 0;
        nn = 0;
        repeat (3) @(posedge mclk);
        instr_last <= 1'b1;
        @(posedge mclk);
        instr_last <= 1'b0;
        repeat (6) begin
            #1;
            ni += (irq_take_q === 1'b1);
            nn += (nmi_take_q === 1'b1);
            @(posedge mclk);
        end
    endtask : pulse_last
    // Prints counts and verdict, then stops
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    // Main sequence
    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge mclk);
        for (j = 0; j < 15; j++)
            bus_cycle(kinds[j % 5], j % 3);
        $display("bus cycles done");
        for (j = 0; j < 2; j++) begin
            usr_irq <= 1'b1;
            irq_enable_flag <= j[0];
            pulse_last();
            chk(ni, j);
        end
        usr_irq <= 1'b0;
        irq_enable_flag <= 1'b0;
        usr_nmi <= 1'b1;
        pulse_last();
        chk(nn, 1);
        chk(irq_type_q, 8'h02);
        pulse_last();
        chk(nn, 0);
        usr_nmi <= 1'b0;
        $display("interrupts done");
        wait_instr <= 1'b1;
        usr_test_n <= 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        chk(wait_idle, 1'b1);
        @(posedge mclk);
        usr_test_n <= 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        chk(wait_idle, 1'b0);
        @(posedge mclk);
        wait_instr <= 1'b0;
        lock_prefix <= 1'b1;
        for (j = 0; j < 2; j++) begin
            @(posedge mclk);
            lock_prefix <= 1'b0;
            instr_last <= 1'b1;
            @(posedge mclk);
            instr_last <= 1'b0;
            repeat (2) @(posedge mclk);
            #1;
            chk(lbi_bus_if_i.lock_n, j[0]);
        end
        for (j = 0; j < 4; j++) begin
            @(posedge mclk);
            queue_op <= j[1:0];
            @(posedge mclk);
            queue_op <= 2'h0;
            #1;
            chk(lbi_bus_if_i.queue_status_pair, j[1:0]);
        end
        chk(max_mode, 1'b1);
        $display("wait lock queue done");
        for (j = 0; j < 2; j++) begin
            @(posedge mclk);
            usr_bus_chan <= j[0];
            usr_bus_want <= 1'b1;
            cmd_valid <= 1'b1;
            repeat (12) @(posedge mclk);
            #1;
            chk({hold_active, usr_bus_owned, cmd_ready}, 3'h6);
            chk({lbi_bus_if_i.ad_oe_n, lbi_bus_if_i.upper_oe_n, lbi_bus_if_i.ctl_oe_n},
                18'h3FFFF);
            @(posedge mclk);
            cmd_valid <= 1'b0;
            usr_bus_want <= 1'b0;
            repeat (8) @(posedge mclk);
            #1;
            chk(hold_active, 1'b0);
        end
        $display("bus exchange done");
        @(posedge mclk);
        usr_reset_req <= 1'b1;
        @(posedge mclk);
        usr_reset_req <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk({lbi_bus_if_i.cycle_status_lines, lbi_bus_if_i.rd_n}, 4'hF);
        bus_cycle(3'h5, 1);
        $display("reset done");
        finish_test();
    end
endmodule : cpu_local_bus_interface_tb
